// ### logic/rfas_cfg.svh
// Purpose: constants of the register field access bank
// Assumes: 32-bit AHB-Lite data, word aligned registers
// Notes:   offsets are byte addresses
`ifndef RFAS_CFG_SVH
`define RFAS_CFG_SVH

// register byte offsets
`define RFAS_OFS_ERR_SUMMARY  8'h00
`define RFAS_OFS_FIELD_DEMO   8'h04
`define RFAS_OFS_CAPTURE      8'h08
`define RFAS_OFS_STATUS       8'h0C

// error summary field positions
`define RFAS_ERR_BUS_BIT      0
`define RFAS_ERR_IRQ_BIT      1
`define RFAS_ERR_TRAP_BIT     2
`define RFAS_ERR_EN_BIT       11
`define RFAS_ERR_CMD_LO       16
`define RFAS_ERR_CMD_HI       23

// field demo positions
`define RFAS_DEMO_RW_LO       0
`define RFAS_DEMO_RW_HI       7
`define RFAS_DEMO_WO_LO       8
`define RFAS_DEMO_WO_HI       15
`define RFAS_DEMO_WZ_LO       16
`define RFAS_DEMO_WZ_HI       23
`define RFAS_DEMO_MBZ_LO      28
`define RFAS_DEMO_MBZ_HI      31
`define RFAS_DEMO_ONES        2'b11
`define RFAS_DEMO_ONE_LO      24
`define RFAS_DEMO_ONE_HI      25

// capture and status positions
`define RFAS_CAP_FULL_BIT     31
`define RFAS_STAT_RSVD_BIT    0
`define RFAS_STAT_FULL_BIT    8
`define RFAS_CAP_VAL_LO       0
`define RFAS_CAP_VAL_HI       7

// power-up values
`define RFAS_RST_FLAG         1'b0
`define RFAS_RST_BYTE         8'h00
`define RFAS_RST_WORD         32'h0000_0000

`endif

// ### logic/rfas_pkg.sv
// Purpose: types of the register field access bank
// Assumes: rfas_cfg.svh holds every number
// Notes:   whole module state is one packed struct
`default_nettype none
package rfas_pkg;

   // error events from the core, same clock
   typedef struct packed {
      logic       bus_err;
      logic       irq_err;
      logic       trap_err;
      logic [7:0] cmd;
   } rfas_err_evt_t;

   // hardware capture request for the read-to-clear field
   typedef struct packed {
      logic       load;
      logic [7:0] data;
   } rfas_cap_t;

   typedef struct packed {
      logic        pend_wr;
      logic        pend_rd;
      logic        priv;
      logic [7:0]  addr;
      logic        hready;
      logic        hresp;
      logic [31:0] rdata;
      logic        bus_flt;
      logic        irq_rep;
      logic        trap_rep;
      logic        irq_en;
      logic [7:0]  fail_cmd;
      logic [7:0]  rw_val;
      logic [7:0]  wo_val;
      logic [7:0]  wz_val;
      logic        wz_strobe;
      logic        rsvd_flag;
      logic        rsvd_pulse;
      logic [7:0]  cap_val;
      logic        cap_full;
      logic        err_irq;
   } rfas_state_t;

endpackage
`default_nettype wire

// ### logic/rfas_bank.sv
// Purpose: register bank showing each field access type on AHB-Lite
// Assumes: one slave on the bus, single word transfers, 100 MHz hclk
// Notes:   writes take no wait state, reads take one
//          hsize is not checked, every access is taken as a word
//          unprivileged writes are dropped, unprivileged reads give zero
//          a hardware set beats a software clear in the same cycle
//          capture load is refused while full, also at the clearing read
//          a must-be-zero violation drops the whole field demo write
//
// Overview of operation
// R1 - read-write field returns last stored value, takes updates
// R2 - read-only field changes by hardware only, writes ignored
// R3 - write-only field stored for hardware, read value not to be used
// R4 - write-only field used by hardware, always reads zero
// R5 - write-one-to-clear bit readable, one clears, zero leaves it
// R6 - read-to-clear field holds capture until read, then reloads
// R7 - constant zero positions read zero, writes ignored
// R8 - constant one positions read one, writes ignored
// R9 - positions without storage ignore writes, read value arbitrary
// R10 - nonzero must-be-zero field raises reserved operand exception
// R11 - software writes zero into should-be-zero fields
// R12 - initialised fields take their power-up value
// R13 - bus fault flag at bit 0, write-one-to-clear, powers up zero
// R14 - interrupt report flag at bit 1, write-one-to-clear, zero
// R15 - trap report flag at bit 2, write-one-to-clear, zero
// R16 - error interrupt enable at bit 11, read-write, zero blocks
// R17 - failing command bits 23:16 latch command at error
// R18 - no operation may leave the bank unable to continue
// R19 - only privileged accesses reach the registers
// R20 - unnamed bits of the error register read zero
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`include "rfas_cfg.svh"
`default_nettype none
module rfas_bank (
   input  wire logic                   hclk,
   input  wire logic                   hresetn,
   input  wire logic                   hsel,
   input  wire logic [7:0]             haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [3:0]             hprot,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic                        hreadyout,
   output logic                        hresp,
   output logic [31:0]                 hrdata,
   input  wire rfas_pkg::rfas_err_evt_t err_evt,
   input  wire rfas_pkg::rfas_cap_t    cap_in,
   output logic [7:0]                  rw_value,
   output logic [7:0]                  wo_value,
   output logic [7:0]                  wz_value,
   output logic                        wz_strobe,
   output logic                        rsvd_op_exc,
   output logic                        err_irq,
   output logic                        cap_full
);
   import rfas_pkg::*;

   rfas_state_t s_q;
   rfas_state_t s_d;
   logic        accept;
   logic        any_err;

   // word index compare, used by write and read paths
   function automatic logic is_reg(input logic [7:0] a,
                                   input logic [7:0] ofs);
      is_reg = (a[7:2] == ofs[7:2]);
   endfunction

   // register map, one word each, unmapped words read zero
   //   0x00 error summary: flags 0 bus, 1 irq, 2 trap (one clears),
   //        11 enable, 23:16 failing command (read only)
   //   0x04 field demo: 7:0 read-write, 15:8 write-only, 23:16
   //        write-only reads zero, 25:24 fixed ones, 27:26 no storage,
   //        31:28 must be zero
   //   0x08 capture: 7:0 read-to-clear value, 31 full
   //   0x0C status: 0 reserved operand flag (one clears), 8 full

   // error summary word, unnamed bits stay zero
   function automatic logic [31:0] read_err(input rfas_state_t s);
      logic [31:0] r;
      r = `RFAS_RST_WORD;                                       // R20
      r[`RFAS_ERR_BUS_BIT]  = s.bus_flt;                        // R13
      r[`RFAS_ERR_IRQ_BIT]  = s.irq_rep;                        // R14
      r[`RFAS_ERR_TRAP_BIT] = s.trap_rep;                       // R15
      r[`RFAS_ERR_EN_BIT]   = s.irq_en;                         // R16
      r[`RFAS_ERR_CMD_HI:`RFAS_ERR_CMD_LO] = s.fail_cmd;        // R17
      read_err = r;
   endfunction

   // write-only bytes, absent and must-be-zero bits give zero
   function automatic logic [31:0] read_demo(input rfas_state_t s);
      logic [31:0] r;
      r = `RFAS_RST_WORD;                                       // R4 R7 R9
      r[`RFAS_DEMO_RW_HI:`RFAS_DEMO_RW_LO] = s.rw_val;          // R1
      // software must not rely on the write-only byte          // R3
      r[`RFAS_DEMO_ONE_HI:`RFAS_DEMO_ONE_LO] = `RFAS_DEMO_ONES; // R8
      read_demo = r;
   endfunction

   function automatic logic [31:0] read_cap(input rfas_state_t s);
      logic [31:0] r;
      r = `RFAS_RST_WORD;
      r[`RFAS_CAP_VAL_HI:`RFAS_CAP_VAL_LO] = s.cap_val;         // R6
      r[`RFAS_CAP_FULL_BIT] = s.cap_full;                       // R6
      read_cap = r;
   endfunction

   function automatic logic [31:0] read_stat(input rfas_state_t s);
      logic [31:0] r;
      r = `RFAS_RST_WORD;
      r[`RFAS_STAT_RSVD_BIT] = s.rsvd_flag;                     // R10
      r[`RFAS_STAT_FULL_BIT] = s.cap_full;                      // R2
      read_stat = r;
   endfunction

   // read view of every register
   function automatic logic [31:0] read_mux(input rfas_state_t s);
      logic [31:0] r;
      r = `RFAS_RST_WORD;
      if (is_reg(s.addr, `RFAS_OFS_ERR_SUMMARY)) begin
         r = read_err(s);
      end else if (is_reg(s.addr, `RFAS_OFS_FIELD_DEMO)) begin
         r = read_demo(s);
      end else if (is_reg(s.addr, `RFAS_OFS_CAPTURE)) begin
         r = read_cap(s);
      end else if (is_reg(s.addr, `RFAS_OFS_STATUS)) begin
         r = read_stat(s);
      end
      read_mux = r;
   endfunction

   // a written one clears, a written zero keeps the bit
   function automatic logic w1c(input logic cur,
                                input logic wbit);
      w1c = cur & ~wbit;                                        // R5
   endfunction

   // failing command and unnamed bits are not writable
   function automatic rfas_state_t write_err(input rfas_state_t s,
                                             input logic [31:0] d);
      rfas_state_t n;
      n = s;
      n.bus_flt  = w1c(s.bus_flt, d[`RFAS_ERR_BUS_BIT]);        // R13
      n.irq_rep  = w1c(s.irq_rep, d[`RFAS_ERR_IRQ_BIT]);        // R14
      n.trap_rep = w1c(s.trap_rep, d[`RFAS_ERR_TRAP_BIT]);      // R15
      n.irq_en   = d[`RFAS_ERR_EN_BIT];                         // R16
      write_err = n;                                            // R2 R20
   endfunction

   // whole write dropped so no field sees bad data
   function automatic rfas_state_t write_demo(input rfas_state_t s,
                                              input logic [31:0] d);
      rfas_state_t n;
      n = s;
      if (|d[`RFAS_DEMO_MBZ_HI:`RFAS_DEMO_MBZ_LO]) begin
         n.rsvd_pulse = 1'b1;                                   // R10
         n.rsvd_flag  = 1'b1;                                   // R10
      end else begin
         n.rw_val    = d[`RFAS_DEMO_RW_HI:`RFAS_DEMO_RW_LO];    // R1
         n.wo_val    = d[`RFAS_DEMO_WO_HI:`RFAS_DEMO_WO_LO];    // R3
         n.wz_val    = d[`RFAS_DEMO_WZ_HI:`RFAS_DEMO_WZ_LO];    // R4
         n.wz_strobe = 1'b1;                                    // R4
      end
      write_demo = n;                                           // R7 R9
   endfunction

   function automatic rfas_state_t write_stat(input rfas_state_t s,
                                              input logic [31:0] d);
      rfas_state_t n;
      n = s;
      n.rsvd_flag = w1c(s.rsvd_flag, d[`RFAS_STAT_RSVD_BIT]);   // R5
      write_stat = n;
   endfunction

   assign accept  = hsel & hready & htrans[1];
   assign any_err = err_evt.bus_err | err_evt.irq_err | err_evt.trap_err;

   always_comb begin
      s_d            = s_q;
      s_d.wz_strobe  = 1'b0;
      s_d.rsvd_pulse = 1'b0;
      s_d.hresp      = 1'b0;
      s_d.hready     = 1'b1;

      // address phase; hsize is not checked, word access assumed
      s_d.pend_wr = accept & hwrite;
      s_d.pend_rd = accept & ~hwrite;
      if (accept) begin
         s_d.addr = haddr;
         s_d.priv = hprot[1];                                   // R19
      end
      // one wait state lets a write just before a read land first
      if (accept && !hwrite) begin
         s_d.hready = 1'b0;
      end

      // write data phase, ignored without privilege            // R19
      if (s_q.pend_wr && s_q.priv) begin
         if (is_reg(s_q.addr, `RFAS_OFS_ERR_SUMMARY)) begin
            s_d = write_err(s_d, hwdata);                       // R5
         end else if (is_reg(s_q.addr, `RFAS_OFS_FIELD_DEMO)) begin
            s_d = write_demo(s_d, hwdata);                      // R10
         end else if (is_reg(s_q.addr, `RFAS_OFS_STATUS)) begin
            s_d = write_stat(s_d, hwdata);                      // R5
         end
         // capture register and unmapped words ignore writes
      end

      // hardware sets after software clears, so set wins
      if (err_evt.bus_err) begin
         s_d.bus_flt = 1'b1;                                    // R13
      end
      if (err_evt.irq_err) begin
         s_d.irq_rep = 1'b1;                                    // R14
      end
      if (err_evt.trap_err) begin
         s_d.trap_rep = 1'b1;                                   // R15
      end
      if (any_err) begin
         s_d.fail_cmd = err_evt.cmd;                            // R17
      end

      // read data phase; unprivileged or unmapped reads give zero
      if (s_q.pend_rd) begin
         s_d.rdata = s_q.priv ? read_mux(s_q) : `RFAS_RST_WORD; // R19
         if (s_q.priv && is_reg(s_q.addr, `RFAS_OFS_CAPTURE)) begin
            s_d.cap_full = 1'b0;                                // R6
         end
      end

      // reload only once the previous value has been read
      if (cap_in.load && !s_q.cap_full) begin
         s_d.cap_val  = cap_in.data;                            // R6
         s_d.cap_full = 1'b1;                                   // R6
      end

      s_d.err_irq = s_d.irq_en & s_d.irq_rep;                   // R16
   end

   // every state bit has a power-up value; bus state cannot stick
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q.pend_wr    <= 1'b0;                                // R18
         s_q.pend_rd    <= 1'b0;
         s_q.priv       <= 1'b0;
         s_q.addr       <= `RFAS_RST_BYTE;
         s_q.hready     <= 1'b1;
         s_q.hresp      <= 1'b0;
         s_q.rdata      <= `RFAS_RST_WORD;
         s_q.bus_flt    <= `RFAS_RST_FLAG;                      // R12
         s_q.irq_rep    <= `RFAS_RST_FLAG;                      // R12
         s_q.trap_rep   <= `RFAS_RST_FLAG;                      // R12
         s_q.irq_en     <= `RFAS_RST_FLAG;                      // R12
         s_q.fail_cmd   <= `RFAS_RST_BYTE;
         s_q.rw_val     <= `RFAS_RST_BYTE;
         s_q.wo_val     <= `RFAS_RST_BYTE;
         s_q.wz_val     <= `RFAS_RST_BYTE;
         s_q.wz_strobe  <= 1'b0;
         s_q.rsvd_flag  <= 1'b0;
         s_q.rsvd_pulse <= 1'b0;
         s_q.cap_val    <= `RFAS_RST_BYTE;
         s_q.cap_full   <= 1'b0;
         s_q.err_irq    <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign hreadyout   = s_q.hready;
   assign hresp       = s_q.hresp;
   assign hrdata      = s_q.rdata;
   assign rw_value    = s_q.rw_val;
   assign wo_value    = s_q.wo_val;
   assign wz_value    = s_q.wz_val;
   assign wz_strobe   = s_q.wz_strobe;
   assign rsvd_op_exc = s_q.rsvd_pulse;
   assign err_irq     = s_q.err_irq;
   assign cap_full    = s_q.cap_full;

endmodule
`default_nettype wire

// ### sim/rfas_bank_asserts.sv
// Purpose: port checks of rfas_bank
// Assumes: hready is tied to hreadyout
// Notes:   bound from the bench top file
`default_nettype none
module rfas_bank_asserts (
   input wire logic              hclk,
   input wire logic              hresetn,
   input wire logic              hsel,
   input wire logic [7:0]        haddr,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic [3:0]        hprot,
   input wire logic [31:0]       hwdata,
   input wire logic              hready,
   input wire logic              hreadyout,
   input wire logic              hresp,
   input wire logic [31:0]       hrdata,
   input wire rfas_pkg::rfas_cap_t cap_in,
   input wire logic [7:0]        rw_value,
   input wire logic              wz_strobe,
   input wire logic              rsvd_op_exc,
   input wire logic              cap_full
);
   timeunit 1ns;
   timeprecision 1ns;
   import rfas_pkg::*;
   wire logic tk = hsel & hready & htrans[1];
   wire logic rdc = tk & !hwrite & hprot[1] & (haddr[7:2] == 6'h02);
   wire logic [7:0] wd = hwdata[7:0];
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_wr;
      tk && hwrite && hprot[1] && haddr[7:2] == 6'h01;
   endsequence
   sequence s_rd(logic [5:0] w);
      tk && !hwrite && hprot[1] && haddr[7:2] == w;
   endsequence
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   a_read_wait: assert property (
      tk && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_write_fast: assert property (tk && hwrite |=> hreadyout)
      else $error("write stalled");
   a_wz_pulse: assert property (
      s_wr ##1 hwdata[31:28] == 4'h0 |=> wz_strobe)
      else $error("no strobe on field write");
   a_mbz_exc: assert property (
      s_wr ##1 hwdata[31:28] != 4'h0 |=> rsvd_op_exc && !wz_strobe)
      else $error("reserved operand not flagged");
   a_rw_store: assert property (
      s_wr ##1 hwdata[31:28] == 4'h0 |=> rw_value == $past(wd))
      else $error("rw byte not stored");
   a_const_bits: assert property (
      s_rd(6'h01) |-> ##2 hrdata[31:16] == 16'h0300)
      else $error("fixed bits read wrong");
   a_err_unused: assert property (
      s_rd(6'h00) |-> ##2 (hrdata & 32'hFF00_F7F8) == 32'h0)
      else $error("unused error bits set");
   a_unpriv_zero: assert property (
      tk && !hwrite && !hprot[1] |-> ##2 hrdata == 32'h0)
      else $error("unprivileged read not zero");
   a_cap_take: assert property (cap_in.load && !cap_full |=> cap_full)
      else $error("capture not taken");
   a_cap_hold: assert property (
      cap_full && !rdc && !$past(rdc) |=> cap_full)
      else $error("capture lost before read");
endmodule
`default_nettype wire

// ### sim/rfas_bank_bench.sv
// Purpose: self-checking bench of rfas_bank
// Assumes: one AHB-Lite master, hready taken from hreadyout
// Notes:   read data checked from a queue by a monitor
`default_nettype none
module rfas_bank_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import rfas_pkg::*;
   logic          hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [7:0]    haddr = 8'h00, rw, wo, wz, r = 8'h19;
   logic [1:0]    htrans = 2'h0;
   logic [3:0]    hprot = 4'h0;
   logic [31:0]   hwdata = 32'h0, hrdata;
   logic          hreadyout, hresp, wzs, rsv, irq, full, ww = 1'b0;
   rfas_err_evt_t err_evt = '0;
   rfas_cap_t     cap_in = '0;
   logic [63:0]   q[$];
   int            errors = 0, compares = 0;
   rfas_bank u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hprot(hprot), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .err_evt(err_evt), .cap_in(cap_in), .rw_value(rw),
      .wo_value(wo), .wz_value(wz), .wz_strobe(wzs),
      .rsvd_op_exc(rsv), .err_irq(irq), .cap_full(full));
   initial begin
      forever #5 hclk = ~hclk;
   end
   function automatic logic [7:0] nx(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input string n, input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic finish_test;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // address phase held until hready, then data phase until hready
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic p);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      hprot <= {2'h0, p, 1'b1};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask
   task automatic rd(input logic [7:0] a, input logic p,
                     input logic [31:0] e, m);
      q.push_back({m, e});
      bus(1'b0, a, 32'h0, p);
   endtask
   task automatic ev(input logic [2:0] k, input logic [7:0] c);
      err_evt <= {k, c};
      @(posedge hclk);
      err_evt <= '0;
      @(posedge hclk);
   endtask
   always @(posedge hclk) begin
      if (ww && hreadyout === 1'b1 && q.size() > 0) begin
         chk("hrdata", hrdata & q[0][63:32], q[0][31:0]);
         void'(q.pop_front());
      end
      ww <= (hreadyout === 1'b0);
   end
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(8'h00, 1'b1, 32'h0, 32'hFFFF_FFFF);
      rd(8'h08, 1'b1, 32'h0, 32'hFFFF_FFFF);
      rd(8'h0C, 1'b1, 32'h0, 32'hFFFF_FFFF);
      for (int i = 0; i < 4; i++) begin
         r = nx(r);
         bus(1'b1, 8'h04, {8'h0F, r, r, r}, 1'b1);
         // wo byte and absent bits are masked, their read is not defined
         rd(8'h04, 1'b1, {8'h03, 16'h0, r}, 32'hF3FF_00FF);
         chk("rw", 32'(rw), 32'(r));
         chk("wo", 32'(wo), 32'(r));
         chk("wz", 32'(wz), 32'(r));
      end
      bus(1'b1, 8'h04, {8'h50, ~r, ~r, ~r}, 1'b1);
      rd(8'h0C, 1'b1, 32'h1, 32'h1);
      chk("mbz", 32'(rw), 32'(r));
      bus(1'b1, 8'h0C, 32'h0, 1'b1);
      rd(8'h0C, 1'b1, 32'h1, 32'h1);
      bus(1'b1, 8'h0C, 32'h1, 1'b1);
      rd(8'h0C, 1'b1, 32'h0, 32'h1);
      bus(1'b1, 8'h04, {8'h00, ~r, ~r, ~r}, 1'b0);
      rd(8'h04, 1'b0, 32'h0, 32'hFFFF_FFFF);
      chk("priv", 32'(rw), 32'(r));
      bus(1'b1, 8'h10, 32'hFFFF_FFFF, 1'b1);
      rd(8'h10, 1'b1, 32'h0, 32'hFFFF_FFFF);
      r = nx(r);
      ev(3'b100, r);
      ev(3'b010, r);
      @(posedge hclk);
      chk("irq off", 32'(irq), 32'h0);
      rd(8'h00, 1'b1, {8'h0, r, 16'h0003}, 32'hFFFF_FFFF);
      bus(1'b1, 8'h00, 32'hFFFF_F800, 1'b1);
      repeat (2) @(posedge hclk);
      chk("irq on", 32'(irq), 32'h1);
      ev(3'b001, nx(r));
      rd(8'h00, 1'b1, {8'h0, nx(r), 16'h0807}, 32'hFFFF_FFFF);
      bus(1'b1, 8'h00, 32'h0000_0803, 1'b1);
      rd(8'h00, 1'b1, {8'h0, nx(r), 16'h0804}, 32'hFFFF_FFFF);
      chk("irq clr", 32'(irq), 32'h0);
      cap_in <= {1'b1, 8'hA5};
      @(posedge hclk);
      cap_in <= {1'b1, 8'h5A};
      @(posedge hclk);
      cap_in <= '0;
      rd(8'h08, 1'b1, 32'h8000_00A5, 32'h8000_00FF);
      rd(8'h08, 1'b1, 32'h0, 32'h8000_0000);
      cap_in <= {1'b1, 8'h3C};
      @(posedge hclk);
      cap_in <= '0;
      rd(8'h08, 1'b1, 32'h8000_003C, 32'h8000_00FF);
      finish_test;
   end
   initial begin
      #100000;
      errors++;
      finish_test;
   end
endmodule
bind rfas_bank rfas_bank_asserts u_chk (.*);
`default_nettype wire
